// ==== rtl/sfcs_spi_fifo_ctrl.sv ====
// SPI slave with transmit and receive FIFOs, control, status and interrupt registers.
// Assumes an APB master on clk and an SPI master in mode 0 whose pins are asynchronous.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
module sfcs_spi_fifo_ctrl import sfcs_pkg::*; #(
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic mosi_in,
	output logic miso_out,
	output logic miso_oe,
	output logic irq
);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] CNT_ONE = CW'(1);
	localparam logic [CW-1:0] CNT_FULL = CW'(1 << AW);
	localparam logic [AW-1:0] PTR_ONE = AW'(1);
	localparam logic [4:0] BIT_ONE = 5'h01;
	localparam logic [3:0] WAIT_ONE = 4'h1;

	//--------------------------------------------------------------------------
	// Registers
	//--------------------------------------------------------------------------
	sfcs_apb_st_t ap_st_ff, nxt_ap_st;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff, rx_pop_ok_ff;
	logic [4:0] frame_ff;
	sfcs_cfg_t cfg_ff;
	logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff, nxt_irq_stat;
	logic irq_ff;
	logic [2:0] sync1_ff, sync2_ff;
	logic [1:0] sync3_ff;
	logic [1:0] mosi_dly_ff;
	logic [AW-1:0] tx_wr_ff, tx_rd_ff, rx_wr_ff, rx_rd_ff;
	logic [CW-1:0] tx_cnt_ff, rx_cnt_ff;
	logic [31:0] tx_sh_ff, rx_sh_ff;
	logic [4:0] bitpos_ff;
	logic [3:0] wait_left_ff;
	logic in_frame_ff, load_req_ff;
	logic miso_ff, miso_oe_ff;

	//--------------------------------------------------------------------------
	// APB decode
	//--------------------------------------------------------------------------
	wire access = psel & penable;
	wire ap_done = (ap_st_ff == SFCS_AP_DONE);
	wire hit_frame = (paddr == ADDR_FRAME);
	wire hit_ctrl = (paddr == ADDR_CTRL);
	wire hit_data = (paddr == ADDR_DATA);
	wire hit_stat = (paddr == ADDR_STAT);
	wire hit_istat = (paddr == ADDR_IRQ_STAT);
	wire hit_imask = (paddr == ADDR_IRQ_MASK);
	wire mapped = hit_frame | hit_ctrl | hit_data | hit_stat | hit_istat | hit_imask;
	wire wr_done = ap_done & pwrite & mapped;
	wire wr_data = wr_done & hit_data;
	wire rd_data_done = ap_done & ~pwrite & hit_data;
	wire stat_load = (ap_st_ff == SFCS_AP_WAIT) & ~pwrite & hit_stat;

	always_comb begin
		case (ap_st_ff)
			SFCS_AP_IDLE: nxt_ap_st = access ? SFCS_AP_WAIT : SFCS_AP_IDLE;
			SFCS_AP_WAIT: nxt_ap_st = SFCS_AP_DONE;
			SFCS_AP_DONE: nxt_ap_st = SFCS_AP_IDLE;
			default: nxt_ap_st = SFCS_AP_IDLE;
		endcase
	end

	//--------------------------------------------------------------------------
	// FIFO bookkeeping
	//--------------------------------------------------------------------------
	wire tx_empty = (tx_cnt_ff == '0);
	wire tx_full = (tx_cnt_ff == CNT_FULL);
	wire rx_empty = (rx_cnt_ff == '0);
	wire rx_full = (rx_cnt_ff == CNT_FULL);
	wire [31:0] tx_rdata;
	wire [31:0] rx_rdata;

	// Pushes into a full transmit FIFO are dropped
	wire tx_push = wr_data & ~tx_full;
	wire rx_pop = rd_data_done & rx_pop_ok_ff;

	//--------------------------------------------------------------------------
	// Serial side
	//--------------------------------------------------------------------------
	// Sync order: [0] sclk, [1] cs_n, [2] mosi
	wire sclk_s = sync2_ff[0];
	wire sel = ~sync2_ff[1];
	wire sel_start = sel & sync3_ff[1];
	wire rise = sclk_s & ~sync3_ff[0];
	wire fall = ~sclk_s & sync3_ff[0];
	wire mosi_pick = cfg_ff.input_delay_en ? mosi_dly_ff[1] : sync2_ff[2];

	wire tx_load = sel & (sel_start | (fall & load_req_ff));
	wire tx_pop = tx_load & ~tx_empty;
	// Underrun sends zeros rather than stalling the master
	wire [31:0] tx_next = tx_empty ? '0 : sfcs_order(tx_rdata, cfg_ff.tx_order_format,
		frame_ff);
	wire [31:0] nxt_tx_sh = tx_load ? tx_next : (fall & in_frame_ff) ? (tx_sh_ff >> 1) : tx_sh_ff;

	wire sample = rise & sel & in_frame_ff;
	wire last_bit = (bitpos_ff == frame_ff);
	wire frame_done = sample & last_bit;
	wire [31:0] rx_bit_word = {rx_sh_ff[30:0], mosi_pick};
	wire [31:0] rx_word = rx_bit_word & sfcs_frame_mask(frame_ff);
	wire rx_push = frame_done & ~rx_full;
	wire rx_ovr = frame_done & rx_full;
	wire wait_tick = rise & sel & ~in_frame_ff & (wait_left_ff != '0);

	//--------------------------------------------------------------------------
	// Status and interrupts
	//--------------------------------------------------------------------------
	wire rx_lvl = sfcs_level_met(8'(rx_cnt_ff), cfg_ff.rx_irq_threshold_sel);
	wire tx_lvl = sfcs_level_met(8'(tx_cnt_ff), cfg_ff.tx_irq_threshold_sel);
	wire [IRQ_W-1:0] irq_ev = {rx_ovr, tx_lvl, rx_lvl};
	wire [IRQ_W-1:0] irq_clr = (wr_done & hit_istat) ? pwdata[IRQ_W-1:0] : '0;
	// Irq follows a mask write in the same cycle as the mask register itself
	wire [IRQ_W-1:0] nxt_irq_mask = (wr_done & hit_imask) ? pwdata[IRQ_W-1:0] : irq_mask_ff;

	sfcs_flags_t flags;
	assign flags.tx_fifo_empty_flag = tx_empty;
	assign flags.tx_fifo_space_flag = ~tx_full;
	assign flags.rx_fifo_has_data_flag = ~rx_empty;
	assign flags.rx_fifo_full_flag = rx_full;
	assign flags.transfer_active_flag = in_frame_ff | ~tx_empty;

	wire [31:0] stat_word = {27'h0, flags};
	wire [31:0] frame_word = {27'h0, frame_ff};
	wire [31:0] ctrl_word = (32'(cfg_ff.rx_irq_threshold_sel) << CTRL_RXSEL_LO)
		| (32'(cfg_ff.tx_irq_threshold_sel) << CTRL_TXSEL_LO)
		| (32'(cfg_ff.interframe_wait_count) << CTRL_WAIT_LO)
		| (32'(cfg_ff.tx_order_format) << CTRL_ORDER_LO)
		| (32'(cfg_ff.input_delay_en) << CTRL_INDEL_BIT);
	wire [31:0] data_word = rx_empty ? '0 : rx_rdata;
	wire [31:0] rd_mux = hit_frame ? frame_word
		: hit_ctrl ? ctrl_word
		: hit_data ? data_word
		: hit_stat ? stat_word
		: hit_istat ? 32'(irq_stat_ff)
		: hit_imask ? 32'(irq_mask_ff) : '0;

	// Set wins over a write-one clear in the same cycle
	assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_ev;

	//--------------------------------------------------------------------------
	// APB slave
	//--------------------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ap_st_ff <= SFCS_AP_IDLE;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
			rx_pop_ok_ff <= 1'b0;
		end else begin
			ap_st_ff <= nxt_ap_st;
			pready_ff <= (nxt_ap_st == SFCS_AP_DONE);
			if (ap_st_ff == SFCS_AP_WAIT) begin
				pslverr_ff <= ~mapped;
				prdata_ff <= pwrite ? '0 : rd_mux;
				rx_pop_ok_ff <= ~pwrite & hit_data & ~rx_empty;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			frame_ff <= FRAME_RST;
			cfg_ff <= '0;
			irq_mask_ff <= '0;
		end else begin
			if (wr_done & hit_frame) begin
				frame_ff <= pwdata[4:0];
			end
			if (wr_done & hit_ctrl) begin
				cfg_ff.rx_irq_threshold_sel <= pwdata[CTRL_RXSEL_LO +: 3];
				cfg_ff.tx_irq_threshold_sel <= pwdata[CTRL_TXSEL_LO +: 3];
				cfg_ff.interframe_wait_count <= pwdata[CTRL_WAIT_LO +: 4];
				cfg_ff.tx_order_format <= pwdata[CTRL_ORDER_LO +: 2];
				cfg_ff.input_delay_en <= pwdata[CTRL_INDEL_BIT];
			end
			irq_mask_ff <= nxt_irq_mask;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_stat_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
		end
	end

	//--------------------------------------------------------------------------
	// FIFO pointers and memories
	//--------------------------------------------------------------------------
	wire [AW-1:0] nxt_tx_rd = tx_pop ? tx_rd_ff + PTR_ONE : tx_rd_ff;
	wire [AW-1:0] nxt_rx_rd = rx_pop ? rx_rd_ff + PTR_ONE : rx_rd_ff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_wr_ff <= '0;
			tx_rd_ff <= '0;
			tx_cnt_ff <= '0;
			rx_wr_ff <= '0;
			rx_rd_ff <= '0;
			rx_cnt_ff <= '0;
		end else begin
			tx_wr_ff <= tx_push ? tx_wr_ff + PTR_ONE : tx_wr_ff;
			tx_rd_ff <= nxt_tx_rd;
			tx_cnt_ff <= tx_cnt_ff + CW'(tx_push) - CW'(tx_pop);
			rx_wr_ff <= rx_push ? rx_wr_ff + PTR_ONE : rx_wr_ff;
			rx_rd_ff <= nxt_rx_rd;
			rx_cnt_ff <= rx_cnt_ff + CW'(rx_push) - CW'(rx_pop);
		end
	end

	// Read address is the next pointer so the head word is ready after a pop
	sfcs_fifo_mem #(.W(32), .AW(AW)) u_tx_mem (
		.clk(clk),
		.resetn(resetn),
		.we(tx_push),
		.waddr(tx_wr_ff),
		.wdata(pwdata),
		.raddr(nxt_tx_rd),
		.rdata(tx_rdata)
	);

	sfcs_fifo_mem #(.W(32), .AW(AW)) u_rx_mem (
		.clk(clk),
		.resetn(resetn),
		.we(rx_push),
		.waddr(rx_wr_ff),
		.wdata(rx_word),
		.raddr(nxt_rx_rd),
		.rdata(rx_rdata)
	);

	//--------------------------------------------------------------------------
	// Pin synchronisers and frame engine
	//--------------------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1_ff <= 3'h2;
			sync2_ff <= 3'h2;
			sync3_ff <= 2'h2;
			mosi_dly_ff <= '0;
		end else begin
			sync1_ff <= {mosi_in, cs_n_in, sclk_in};
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff[1:0];
			mosi_dly_ff <= {mosi_dly_ff[0], sync2_ff[2]};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_sh_ff <= '0;
			rx_sh_ff <= '0;
		end else begin
			tx_sh_ff <= nxt_tx_sh;
			rx_sh_ff <= sample ? rx_bit_word : rx_sh_ff;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			in_frame_ff <= 1'b0;
			bitpos_ff <= '0;
			wait_left_ff <= '0;
			load_req_ff <= 1'b0;
		end else if (!sel) begin
			in_frame_ff <= 1'b0;
			bitpos_ff <= '0;
			wait_left_ff <= '0;
			load_req_ff <= 1'b0;
		end else if (tx_load) begin
			in_frame_ff <= 1'b1;
			bitpos_ff <= '0;
			load_req_ff <= 1'b0;
		end else if (frame_done) begin
			in_frame_ff <= 1'b0;
			bitpos_ff <= '0;
			wait_left_ff <= cfg_ff.interframe_wait_count;
			load_req_ff <= (cfg_ff.interframe_wait_count == '0);
		end else if (sample) begin
			bitpos_ff <= bitpos_ff + BIT_ONE;
		end else if (wait_tick) begin
			wait_left_ff <= wait_left_ff - WAIT_ONE;
			load_req_ff <= (wait_left_ff == WAIT_ONE);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			miso_ff <= 1'b0;
			miso_oe_ff <= 1'b0;
		end else begin
			miso_ff <= sel & nxt_tx_sh[0];
			miso_oe_ff <= sel;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign miso_out = miso_ff;
	assign miso_oe = miso_oe_ff;
	assign irq = irq_ff;

	//--------------------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------------------
	a_rx_level_flag: assert property (@(posedge clk) disable iff (!resetn)
		rx_lvl |=> irq_stat_ff[IRQ_RXLVL]) else $error("rx level not latched");
	a_tx_level_flag: assert property (@(posedge clk) disable iff (!resetn)
		(cfg_ff.tx_irq_threshold_sel == THR_8 && tx_cnt_ff >= CW'(LVL_8)) |=> irq_stat_ff[IRQ_TXLVL])
		else $error("tx level eight not latched");
	a_wait_load: assert property (@(posedge clk) disable iff (!resetn)
		(frame_done && cfg_ff.interframe_wait_count != '0 && !tx_load)
		|=> (wait_left_ff == $past(cfg_ff.interframe_wait_count)) && !load_req_ff)
		else $error("wait count not loaded");
	a_input_delay: assert property (@(posedge clk) disable iff (!resetn)
		cfg_ff.input_delay_en |-> mosi_pick == $past(sync2_ff[2], 2))
		else $error("input delay not two cycles");
	a_rx_pop_count: assert property (@(posedge clk) disable iff (!resetn)
		(rx_pop && !rx_push) |=> rx_cnt_ff == $past(rx_cnt_ff) - CNT_ONE)
		else $error("rx pop did not lower fill");
	a_tx_push_count: assert property (@(posedge clk) disable iff (!resetn)
		(wr_data && !tx_full && !tx_pop) |=> tx_cnt_ff == $past(tx_cnt_ff) + CNT_ONE)
		else $error("tx push did not raise fill");
	a_rx_justify: assert property (@(posedge clk) disable iff (!resetn)
		rx_push |-> (rx_word & ~sfcs_frame_mask(frame_ff)) == '0)
		else $error("rx word not right justified");
	a_stat_tx_bits: assert property (@(posedge clk) disable iff (!resetn)
		stat_load |=> prdata_ff[STAT_TFE] == $past(tx_cnt_ff == '0)
		&& prdata_ff[STAT_TNF] == $past(tx_cnt_ff != CNT_FULL)) else $error("tx flags wrong");
	a_stat_rx_bits: assert property (@(posedge clk) disable iff (!resetn)
		stat_load |=> prdata_ff[STAT_RNE] == $past(rx_cnt_ff != '0)
		&& prdata_ff[STAT_RFF] == $past(rx_cnt_ff == CNT_FULL)) else $error("rx flags wrong");
	a_busy_flag: assert property (@(posedge clk) disable iff (!resetn)
		(stat_load && (in_frame_ff || tx_cnt_ff != '0)) |=> prdata_ff[STAT_BSY])
		else $error("busy flag missing");
	a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
		irq_ff == (|(irq_stat_ff & irq_mask_ff))) else $error("irq differs from pending bits");
endmodule

// ==== rtl/sfcs_pkg.sv ====
// Constants, types and helper functions of the SPI FIFO control and status block.
// Assumes a 32-bit APB slave and an external SPI master in clock mode 0.
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
// Summary of operation
// - Receive level flag when receive FIFO holds 1, 4 or 8 words.
// - Transmit level flag when transmit FIFO holds 1, 4 or 8 words.
// - Wait states between consecutive frames, count set by a four-bit field.
// - Transmit order code picks byte order and bit order of each frame.
// - Input delay bit adds two clock cycles to the serial data input.
// - Reading the data port pops and returns one receive FIFO word.
// - Writing the data port pushes the word into the transmit FIFO.
// - Transmit logic ignores data bits above the frame size.
// - Received frames are right-justified with zeros above the frame size.
// - Status bit 0 shows transmit FIFO empty, reset value one.
// - Status bit 1 shows transmit FIFO not full, reset value one.
// - Status bit 2 shows receive FIFO not empty, reset value zero.
// - Status bit 3 shows receive FIFO full, reset value zero.
// - Busy bit 4 is set during a frame or while transmit FIFO is not empty.
package sfcs_pkg;

	//--------------------------------------------------------------------------
	// Register map
	//--------------------------------------------------------------------------
	localparam logic [7:0] ADDR_FRAME = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_DATA = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h30;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;

	// Control register field positions
	localparam int CTRL_RXSEL_LO = 7;
	localparam int CTRL_TXSEL_LO = 10;
	localparam int CTRL_WAIT_LO = 14;
	localparam int CTRL_ORDER_LO = 18;
	localparam int CTRL_INDEL_BIT = 21;

	// Status bits
	localparam int STAT_TFE = 0;
	localparam int STAT_TNF = 1;
	localparam int STAT_RNE = 2;
	localparam int STAT_RFF = 3;
	localparam int STAT_BSY = 4;

	// Interrupt bits
	localparam int IRQ_RXLVL = 0;
	localparam int IRQ_TXLVL = 1;
	localparam int IRQ_RXOVR = 2;
	localparam int IRQ_W = 3;

	localparam logic [2:0] THR_1 = 3'h0;
	localparam logic [2:0] THR_4 = 3'h1;
	localparam logic [2:0] THR_8 = 3'h2;
	localparam logic [7:0] LVL_1 = 8'h01;
	localparam logic [7:0] LVL_4 = 8'h04;
	localparam logic [7:0] LVL_8 = 8'h08;

	localparam logic [1:0] ORD_MSBY_MSBI = 2'h0;
	localparam logic [1:0] ORD_LSBY_MSBI = 2'h1;
	localparam logic [1:0] ORD_MSBY_LSBI = 2'h2;
	localparam int BYTE_BITS = 8;

	// Frame size is stored as size minus one
	localparam logic [4:0] FRAME_RST = 5'h07;
	localparam logic [4:0] FRAME_MAX_M1 = 5'h1f;
	localparam logic [31:0] ALL_ONES = 32'hffffffff;

	//--------------------------------------------------------------------------
	// Types
	//--------------------------------------------------------------------------
	typedef struct packed {
		logic [2:0] rx_irq_threshold_sel;
		logic [2:0] tx_irq_threshold_sel;
		logic [3:0] interframe_wait_count;
		logic [1:0] tx_order_format;
		logic input_delay_en;
	} sfcs_cfg_t;

	typedef struct packed {
		logic transfer_active_flag;
		logic rx_fifo_full_flag;
		logic rx_fifo_has_data_flag;
		logic tx_fifo_space_flag;
		logic tx_fifo_empty_flag;
	} sfcs_flags_t;

	typedef enum logic [2:0] {
		SFCS_AP_IDLE = 3'b001,
		SFCS_AP_WAIT = 3'b010,
		SFCS_AP_DONE = 3'b100
	} sfcs_apb_st_t;

	//--------------------------------------------------------------------------
	// Functions
	//--------------------------------------------------------------------------
	function automatic logic sfcs_level_met(input logic [7:0] fill, input logic [2:0] sel);
		logic met;
		case (sel)
			THR_1: met = (fill >= LVL_1);
			THR_4: met = (fill >= LVL_4);
			THR_8: met = (fill >= LVL_8);
			default: met = 1'b0;
		endcase
		return met;
	endfunction

	function automatic logic [31:0] sfcs_frame_mask(input logic [4:0] fsm1);
		return ALL_ONES >> (FRAME_MAX_M1 - fsm1);
	endfunction

	// Bit k of the result is the k-th bit on the wire; bits above the frame are dropped
	function automatic logic [31:0] sfcs_order(input logic [31:0] w, input logic [1:0] fmt,
			input logic [4:0] fsm1);
		logic [31:0] s;
		int fs;
		int nb;
		int src;
		s = '0;
		fs = int'(fsm1) + 1;
		nb = fs / BYTE_BITS;
		for (int k = 0; k < 32; k++) begin
			case (fmt)
				ORD_MSBY_MSBI: src = fs - 1 - k;
				ORD_LSBY_MSBI: src = BYTE_BITS * (k / BYTE_BITS) + BYTE_BITS - 1 - (k % BYTE_BITS);
				ORD_MSBY_LSBI: src = BYTE_BITS * (nb - 1 - k / BYTE_BITS) + (k % BYTE_BITS);
				default: src = k;
			endcase
			if (k < fs && src >= 0 && src < fs) begin
				s[k] = w[src];
			end
		end
		return s;
	endfunction

endpackage

// ==== rtl/sfcs_fifo_mem.sv ====
// Word store of one FIFO, written on one port and read on another.
// Read data is registered and shows a write to the same address in the same cycle.
`timescale 1ns/1ns
module sfcs_fifo_mem #(
	parameter int W = 32,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [0:(1<<AW)-1];
	logic [W-1:0] rdata_ff;
	wire bypass = we && (waddr == raddr);

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Write-first so a word pushed into an empty FIFO is seen next cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= bypass ? wdata : mem[raddr];
		end
	end

	assign rdata = rdata_ff;
endmodule

// ==== bench/sfcs_spi_master_model.sv ====
// Behavioural SPI master in mode 0 for the serial side of the FIFO block.
// Assumes a slave that updates miso within 200 ns of a clock fall.
`timescale 1ns/1ns
module sfcs_spi_master_model (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	// Low 250 ns, high 150 ns: 400 ns period with slack for the slave's synchronizer
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	task automatic frame(input logic [31:0] w, input int nb, input int gap,
			output logic [31:0] r);
		r = '0;
		for (int i = nb - 1; i >= 0; i--) begin
			mosi = w[i];
			#250 sclk = 1'b1;
			r = {r[30:0], miso & miso_oe};
			#150 sclk = 1'b0;
		end
		// Wait pulses the slave must skip; data toggles so a miscount shows
		repeat (gap) begin
			mosi = ~mosi;
			#250 sclk = 1'b1;
			#150 sclk = 1'b0;
		end
	endtask

	task automatic xfer(input logic [31:0] a, input logic [31:0] b, input int nb,
			input int nf, input int gap, output logic [31:0] ra, output logic [31:0] rb);
		rb = '0;
		// Offset keeps every pin change off the block's clock edges
		#10 cs_n = 1'b0;
		frame(a, nb, (nf > 1) ? gap : 0, ra);
		if (nf > 1) begin
			frame(b, nb, 0, rb);
		end
		#400 cs_n = 1'b1;
		// Released line shows no stale copy of the last bit
		mosi = ~mosi;
	endtask
endmodule

// ==== bench/test_spi_fifo_control_status.sv ====
// Self-checking bench of the SPI FIFO block: APB master tasks and SPI master model.
// Assumes the design answers APB by pready and acts as mode 0 slave.
`timescale 1ns/1ns
module test_spi_fifo_control_status import sfcs_pkg::*;;
	logic clk;
	logic resetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso_out;
	logic miso_oe;
	logic irq;
	logic rd_e;
	logic [31:0] rd_d;
	logic [31:0] seed;
	logic [31:0] txw [20];
	logic [31:0] mow [20];
	logic [31:0] r1;
	logic [31:0] r2;
	int fails;
	int n_compared;

	sfcs_spi_fifo_ctrl #(.AW(4)) sfcs_spi_fifo_ctrl_i (.clk(clk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_in(sclk),
		.cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso_out), .miso_oe(miso_oe), .irq(irq));
	sfcs_spi_master_model sfcs_spi_master_model_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso_out), .miso_oe(miso_oe));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	//--------------------------------------------------------------------------
	// Expectations
	//--------------------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic met(input int k, input logic [2:0] s);
		case (s)
			3'h0: return k >= 1;
			3'h1: return k >= 4;
			3'h2: return k >= 8;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] ctl(input logic [2:0] s, input logic [1:0] o,
			input logic [3:0] wt, input logic dl);
		return (32'(s) << CTRL_RXSEL_LO) | (32'(s) << CTRL_TXSEL_LO) |
			(32'(wt) << CTRL_WAIT_LO) | (32'(o) << CTRL_ORDER_LO) | (32'(dl) << CTRL_INDEL_BIT);
	endfunction

	// Word as the master collects it: first wire bit ends up highest
	function automatic logic [31:0] exp_wire(input logic [31:0] w, input logic [1:0] f,
			input int nb);
		logic [31:0] r;
		int s;
		r = '0;
		for (int k = 0; k < nb; k++) begin
			case (f)
				2'h0: s = nb - 1 - k;
				2'h1: s = 8 * (k / 8) + 7 - k % 8;
				2'h2: s = 8 * (nb / 8 - 1 - k / 8) + k % 8;
				default: s = k;
			endcase
			r[nb - 1 - k] = w[s];
		end
		return r;
	endfunction

	//--------------------------------------------------------------------------
	// Bus and check tasks
	//--------------------------------------------------------------------------
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Answer taken at the rising edge that samples pready high, then released
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd_d = prdata;
		rd_e = pslverr;
		if (n >= 20) chk(32'h0, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd_d, e);
	endtask

	task burst(input int n, input logic [2:0] s, input logic [1:0] o);
		// One wait state: with none, the closing clock fall preloads and pops a word
		apb(1'b1, ADDR_CTRL, ctl(s, o, 4'h1, 1'b0));
		for (int i = 0; i < n; i++) begin
			seed = lfsr(seed);
			txw[i] = seed;
			apb(1'b1, ADDR_DATA, seed);
			rd(ADDR_IRQ_STAT, {30'h0, met(i + 1, s), 1'b0});
		end
		chk(32'(irq), 32'(met(n, s)));
		rd(ADDR_STAT, {27'h0, 1'b1, 2'b00, n < 16, 1'b0});
		if (s == THR_1) begin
			apb(1'b1, ADDR_IRQ_MASK, 32'h0);
			rd(ADDR_IRQ_MASK, 32'h0);
			chk(32'(irq), 32'h0);
			apb(1'b1, ADDR_IRQ_MASK, 32'h3);
		end
		for (int i = 0; i < n; i++) begin
			seed = lfsr(seed);
			mow[i] = seed;
			sfcs_spi_master_model_i.xfer(seed, 32'h0, 8, 1, 0, r1, r2);
			chk(r1, (i < 16) ? exp_wire(txw[i], o, 8) : 32'h0);
			rd(ADDR_IRQ_STAT, {29'h0, i > 15, met(n, s), met(i + 1, s)});
		end
		rd(ADDR_STAT, {27'h0, 1'b0, n >= 16, 3'b111});
		for (int i = 0; i < n && i < 16; i++) begin
			rd(ADDR_DATA, mow[i] & 32'hff);
		end
		rd(ADDR_DATA, 32'h0);
		apb(1'b1, ADDR_IRQ_STAT, 32'h7);
		rd(ADDR_IRQ_STAT, 32'h0);
		chk(32'(irq), 32'h0);
	endtask

	task summarize();
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	//--------------------------------------------------------------------------
	// Main sequence
	//--------------------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		seed = 32'h11;
		fails = 0;
		n_compared = 0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		rd(ADDR_STAT, 32'h3);
		rd(ADDR_CTRL, 32'h0);
		apb(1'b1, ADDR_STAT, 32'h0);
		rd(ADDR_STAT, 32'h3);
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(rd_e), 32'h1);
		apb(1'b1, ADDR_IRQ_MASK, 32'h3);
		for (int c = 0; c < 4; c++) begin
			burst(9, 3'(c), (c % 2 == 1) ? 2'h3 : 2'h0);
		end
		// Overfill both FIFOs: one write and one frame beyond depth
		burst(17, THR_4, 2'h0);
		apb(1'b1, ADDR_FRAME, 32'h1f);
		for (int o = 0; o < 4; o++) begin
			apb(1'b1, ADDR_CTRL, ctl(3'h0, 2'(o), 4'h2, 1'b1));
			for (int j = 0; j < 2; j++) begin
				seed = lfsr(seed);
				txw[j] = seed;
				apb(1'b1, ADDR_DATA, seed);
				seed = lfsr(seed);
				mow[j] = seed;
			end
			sfcs_spi_master_model_i.xfer(mow[0], mow[1], 32, 2, 2, r1, r2);
			chk(r1, exp_wire(txw[0], 2'(o), 32));
			chk(r2, exp_wire(txw[1], 2'(o), 32));
			rd(ADDR_DATA, mow[0]);
			rd(ADDR_DATA, mow[1]);
		end
		summarize();
	end

	// Run needs about 0.4 ms; this limit leaves ample margin
	initial begin
		#3000000;
		fails++;
		summarize();
	end
endmodule
